/* inc/wd_pkg.sv */
// shared constants and types for the windowed supervisor
package wd_pkg;
	// clock and timebase
	localparam int CLK_MHZ = 250;
	localparam int KICK_TICK_PERIOD_US = 500; // fast sampling period, 0.5 ms
	localparam int TICK_CYCLES = (KICK_TICK_PERIOD_US * CLK_MHZ); // cycles per fast tick
	// span lengths in ms, fast timing
	localparam int RESET_HOLD_MS = 16;
	localparam int IGNORE_SPAN_MS = 32;
	localparam int ACCEPT_SPAN_MS = 32;
	localparam int LOCKOUT_SPAN_MS = 32;
	localparam int LONG_SPAN_FACTOR = 4;
	// span lengths in ticks (fast); slow timing doubles the tick period
	localparam int RESET_HOLD_TICKS = RESET_HOLD_MS * 1000 / KICK_TICK_PERIOD_US;
	localparam int IGNORE_SPAN_TICKS = IGNORE_SPAN_MS * 1000 / KICK_TICK_PERIOD_US;
	localparam int ACCEPT_SPAN_TICKS = ACCEPT_SPAN_MS * 1000 / KICK_TICK_PERIOD_US;
	localparam int LOCKOUT_SPAN_TICKS = LOCKOUT_SPAN_MS * 1000 / KICK_TICK_PERIOD_US;
	localparam int LONG_SPAN_TICKS = LONG_SPAN_FACTOR * ACCEPT_SPAN_TICKS;
	localparam int SPAN_W = 8;
	// timing modes from the straps
	typedef enum logic [1:0] {
		MODE_FAST = 2'h0,
		MODE_SLOW = 2'h1,
		MODE_OFF = 2'h2
	} wd_mode_t;
	// strap pair carried together
	typedef struct packed {
		logic strap_a;
		logic strap_b;
	} strap_pair_t;
	// watchdog phase, one-hot
	typedef enum logic [4:0] {
		ST_HOLD = 5'h01,
		ST_IGNORE = 5'h02,
		ST_LONG = 5'h04,
		ST_LOCKOUT = 5'h08,
		ST_ACCEPT = 5'h10
	} wd_state_t;
endpackage

/* logic/kick_sampler.sv */
// kick input sampler: finds a high-high-low-low pattern on tick edges
`timescale 1ns/1ps
`default_nettype none
module kick_sampler (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic tick,
	input wire logic enable,
	input wire logic kick_input,
	output logic trigger
);
	// last four samples, newest in bit 0
	logic [3:0] hist_r;

	// shift on each tick; cleared while disabled so stale highs never count
	always_ff @(posedge clk_sys) begin
		if (rst || !enable) begin
			hist_r <= 4'h0;
		end else if (tick) begin
			hist_r <= {hist_r[2:0], kick_input}; // see R11
		end
	end

	// falling edge after two highs, two lows: one-cycle pulse
	always_ff @(posedge clk_sys) begin
		if (rst || !enable) begin
			trigger <= 1'b0;
		end else begin
			trigger <= tick && (hist_r[2:0] == 3'b110) && !kick_input; // see R10 see R11
		end
	end
endmodule
`default_nettype wire

/* logic/windowed_supervisor.sv */
// windowed watchdog and reset supervisor top
// Summary of operation
// R1: straps select fast, slow or off
// R2: strap_b low fast; a low b high slow
// R3: short hold only when both straps low
// R4: hold reset low after power-on
// R5: undervoltage drives reset low
// R6: reset release starts ignore span
// R7: kicks ignored during ignore span
// R8: then long open span, four accept spans
// R9: no trigger in long span resets
// R10: falling kick edge is the trigger
// R11: sample each tick; two highs, two lows
// R12: trigger in long span starts lockout
// R13: lockout end starts accept span
// R14: trigger in accept span restarts lockout
// R15: accept span expiry resets
// R16: trigger during lockout resets
// R17: host kicks at stable period
// R18: host spaces kicks lockout plus half accept
// R19: watchdog reset holds then restarts ignore
// R20: watchdog off ignores kicks entirely
// R21: all spans counted in whole ticks
`timescale 1ns/1ps
`default_nettype none
module windowed_supervisor #(
	parameter int TICK_CYC = wd_pkg::TICK_CYCLES, // shorten for simulation
	parameter int HOLD_TICKS = wd_pkg::RESET_HOLD_TICKS,
	parameter int IGNORE_TICKS = wd_pkg::IGNORE_SPAN_TICKS,
	parameter int LOCKOUT_TICKS = wd_pkg::LOCKOUT_SPAN_TICKS,
	parameter int ACCEPT_TICKS = wd_pkg::ACCEPT_SPAN_TICKS,
	parameter int LONG_TICKS = wd_pkg::LONG_SPAN_TICKS
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire wd_pkg::strap_pair_t straps,
	input wire logic kick_input,
	input wire logic vout_low,
	output logic reset_out_n,
	output wd_pkg::wd_mode_t mode_out,
	output logic wd_timeout,
	output logic early_kick
);
	import wd_pkg::*;

	// refuse settings the counters cannot hold: the prescaler needs two cycles a tick,
	// and every span, the doubled hold as well, must fit the SPAN_W bit span counter
	if (TICK_CYC < 2) begin
		$error("windowed_supervisor: tick shorter than two cycles");
	end
	// doubled hold is the longest hold span, so it sets the limit
	if (HOLD_TICKS < 1 || HOLD_TICKS * 2 >= 2 ** SPAN_W) begin
		$error("windowed_supervisor: hold span out of range");
	end
	if (IGNORE_TICKS < 1 || IGNORE_TICKS >= 2 ** SPAN_W || LOCKOUT_TICKS < 1 || LOCKOUT_TICKS >= 2 ** SPAN_W) begin
		$error("windowed_supervisor: ignore or lockout span out of range");
	end
	if (ACCEPT_TICKS < 1 || ACCEPT_TICKS >= 2 ** SPAN_W || LONG_TICKS < 1 || LONG_TICKS >= 2 ** SPAN_W) begin
		$error("windowed_supervisor: accept or long span out of range");
	end

	localparam int PRE_W = $clog2(TICK_CYC * 2 + 1);

	// derived mode, combinational from straps
	wd_mode_t mode;
	logic long_hold;
	// phase and counters
	wd_state_t state_r;
	logic [PRE_W-1:0] pre_r;
	logic tick;
	logic [SPAN_W-1:0] span_r;
	logic trigger;
	logic span_done;
	logic wd_on;

	// strap decode
	always_comb begin
		if (!straps.strap_b) begin
			mode = MODE_FAST; // see R1 see R2
		end else if (!straps.strap_a) begin
			mode = MODE_SLOW; // see R2
		end else begin
			mode = MODE_OFF; // see R2
		end
		// slow timing already doubles the hold through its tick, so only a high
		// strap_a (fast or off timing) doubles the hold count itself
		long_hold = straps.strap_a; // see R3
	end

	assign wd_on = (mode != MODE_OFF);

	// tick prescaler; slow timing doubles the tick, so every span doubles
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pre_r <= '0;
			tick <= 1'b0;
		end else if (pre_r >= PRE_W'((mode == MODE_SLOW ? 2 : 1) * TICK_CYC - 1)) begin
			pre_r <= '0;
			tick <= 1'b1; // see R21
		end else begin
			pre_r <= pre_r + PRE_W'(1);
			tick <= 1'b0;
		end
	end

	// sampler only listens in spans where kicks matter
	kick_sampler u_sampler (
		.clk_sys(clk_sys),
		.rst(rst),
		.tick(tick),
		.enable(wd_on && state_r != ST_HOLD && state_r != ST_IGNORE), // see R7 see R20
		.kick_input(kick_input),
		.trigger(trigger)
	);

	// span length per phase, in ticks
	function automatic logic [SPAN_W-1:0] span_len(input wd_state_t s, input logic lh);
		logic [SPAN_W-1:0] len;
		len = SPAN_W'(1);
		unique case (s)
			// short hold only with both straps low
			ST_HOLD: len = lh ? SPAN_W'(HOLD_TICKS * 2) : SPAN_W'(HOLD_TICKS); // see R3
			ST_IGNORE: len = SPAN_W'(IGNORE_TICKS);
			ST_LONG: len = SPAN_W'(LONG_TICKS);
			ST_LOCKOUT: len = SPAN_W'(LOCKOUT_TICKS);
			ST_ACCEPT: len = SPAN_W'(ACCEPT_TICKS);
		endcase
		return len;
	endfunction

	assign span_done = tick && (span_r + SPAN_W'(1) >= span_len(state_r, long_hold));

	// phase machine; undervoltage forces hold from any phase
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= ST_HOLD; // see R4
			span_r <= '0;
			wd_timeout <= 1'b0;
			early_kick <= 1'b0;
		end else begin
			wd_timeout <= 1'b0;
			early_kick <= 1'b0;
			if (vout_low) begin
				state_r <= ST_HOLD; // see R5
				span_r <= '0;
			end else begin
				unique case (state_r)
					// hold always ends into ignore; with the watchdog off the
					// ignore phase is parked and never pulls reset low while off; switched off in long,
					// lockout or accept, it still times out into hold and pulls reset low
					ST_HOLD: begin
						if (span_done) begin
							state_r <= ST_IGNORE; // see R6 see R19 see R20
						end
					end
					// kicks never reach the machine here: the sampler is off
					ST_IGNORE: begin
						if (!wd_on) begin
							// parked while off; counting resumes if the straps turn it on
							state_r <= ST_IGNORE; // see R20
						end else if (span_done) begin
							state_r <= ST_LONG; // see R8
						end
					end
					ST_LONG: begin
						if (trigger) begin
							state_r <= ST_LOCKOUT; // see R12
						end else if (span_done) begin
							state_r <= ST_HOLD; // see R9
							wd_timeout <= 1'b1;
						end
					end
					ST_LOCKOUT: begin
						if (trigger) begin
							state_r <= ST_HOLD; // see R16
							early_kick <= 1'b1;
						end else if (span_done) begin
							state_r <= ST_ACCEPT; // see R13
						end
					end
					ST_ACCEPT: begin
						if (trigger) begin
							state_r <= ST_LOCKOUT; // see R14
						end else if (span_done) begin
							state_r <= ST_HOLD; // see R15
							wd_timeout <= 1'b1;
						end
					end
				endcase
				// span counter restarts on every phase change
				if (trigger || span_done) begin
					span_r <= '0;
				end else if (tick && !(state_r == ST_IGNORE && !wd_on) &&
					!(state_r == ST_HOLD && span_r + SPAN_W'(1) >= span_len(state_r, long_hold))) begin
					span_r <= span_r + SPAN_W'(1); // see R21
				end
			end
		end
	end

	// reset output: low in hold, undervoltage or reset, high in every other phase;
	// registered, so it trails the phase by one cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reset_out_n <= 1'b0;
			mode_out <= MODE_FAST;
		end else begin
			mode_out <= mode;
			if (vout_low) begin
				reset_out_n <= 1'b0; // see R5
			end else if (state_r == ST_HOLD) begin
				// held low for the whole hold span, in every mode
				reset_out_n <= 1'b0; // see R4 see R19
			end else begin
				// released in ignore, long, lockout and accept, and while parked off
				reset_out_n <= 1'b1; // see R20
			end
		end
	end
endmodule
`default_nettype wire

/* test/wd_properties.sv */
// port checker for the windowed supervisor
`timescale 1ns/1ps
`default_nettype none
module wd_properties #(
	parameter int TICK_CYC = 4,
	parameter int HOLD_TICKS = 4,
	parameter int IGNORE_TICKS = 4,
	parameter int LONG_TICKS = 32
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire wd_pkg::strap_pair_t straps,
	input wire logic kick_input,
	input wire logic vout_low,
	input wire logic reset_out_n,
	input wire wd_pkg::wd_mode_t mode_out,
	input wire logic wd_timeout,
	input wire logic early_kick
);
	import wd_pkg::*;
	logic [15:0] lo_r; // cycles reset held low
	logic [15:0] hi_r; // cycles since release
	// span counters, cleared by rst so they never start unknown
	always_ff @(posedge clk_sys) begin
		lo_r <= (rst || reset_out_n) ? 16'h0000 : lo_r + 16'h0001;
		hi_r <= (rst || !reset_out_n) ? 16'h0000 : hi_r + 16'h0001;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_uv; vout_low |-> ##[1:3] !reset_out_n; endproperty
	a_uv: assert property (p_uv) else $error("no reset on undervoltage");
	property p_to; wd_timeout |-> ##[0:2] !reset_out_n; endproperty
	a_to: assert property (p_to) else $error("no reset on timeout");
	property p_ek; early_kick |-> ##[0:2] !reset_out_n; endproperty
	a_ek: assert property (p_ek) else $error("no reset on early kick");
	property p_off; mode_out == MODE_OFF |-> !(wd_timeout || early_kick); endproperty
	a_off: assert property (p_off) else $error("watchdog fired while off");
	property p_dec; !$past(rst) && $stable(straps) |-> mode_out == (!straps.strap_b ? MODE_FAST :
		(straps.strap_a ? MODE_OFF : MODE_SLOW)); endproperty
	a_dec: assert property (p_dec) else $error("bad mode decode");
	property p_hold; $rose(reset_out_n) |-> lo_r >= (HOLD_TICKS - 1) * TICK_CYC; endproperty
	a_hold: assert property (p_hold) else $error("hold too short");
	property p_ign; wd_timeout |-> hi_r >= (IGNORE_TICKS + LONG_TICKS - 1) * TICK_CYC; endproperty
	a_ign: assert property (p_ign) else $error("timeout too soon");
	property p_ek2; early_kick |-> hi_r >= (IGNORE_TICKS + 2) * TICK_CYC; endproperty
	a_ek2: assert property (p_ek2) else $error("kick taken in ignore span");
	property p_pls; (wd_timeout || early_kick) |-> reset_out_n ##1 !(wd_timeout || early_kick); endproperty
	a_pls: assert property (p_pls) else $error("bad fault pulse");
	c_to: cover property (wd_timeout);
	c_ek: cover property (early_kick);
	c_uv: cover property (vout_low && reset_out_n);
endmodule
bind windowed_supervisor wd_properties #(.TICK_CYC(TICK_CYC), .HOLD_TICKS(HOLD_TICKS),
	.IGNORE_TICKS(IGNORE_TICKS), .LONG_TICKS(LONG_TICKS)) u_props (.clk_sys(clk_sys), .rst(rst),
	.straps(straps), .kick_input(kick_input), .vout_low(vout_low), .reset_out_n(reset_out_n),
	.mode_out(mode_out), .wd_timeout(wd_timeout), .early_kick(early_kick));
`default_nettype wire

/* test/host_model.sv */
// host model: square wave on the kick input
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clk_sys,
	input wire logic run,
	input wire logic [7:0] half,
	output logic kick_input
);
	logic [7:0] cnt_r; // cycles into this half
	// each half spans two ticks or more, so falls are clean triggers
	always_ff @(posedge clk_sys) begin
		if (!run || cnt_r >= half) begin
			cnt_r <= 8'h01;
			kick_input <= run ? !kick_input : 1'b1;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
endmodule
`default_nettype wire

/* test/tb_windowed_watchdog_reset.sv */
// testbench for the windowed supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
	$display("unexpected at %0t: %h vs %h", $time, (a), (e)); end end
module tb_windowed_watchdog_reset;
	import wd_pkg::*;
	logic clk_sys, rst, vout_low, run, reset_out_n;
	strap_pair_t straps; // mode straps
	logic [7:0] half; // host half period
	wire logic kick; // host kick line
	wd_mode_t mode_out;
	logic wd_timeout, early_kick; // fault pulses
	int to_cnt = 0; // timeout pulses seen
	int ek_cnt = 0; // early kick pulses seen
	int fail_count = 0;
	int tests_run = 0;
	// hold keeps its full default of 32 ticks: 128 cycles short, 256 doubled
	windowed_supervisor #(.TICK_CYC(4), .IGNORE_TICKS(4), .LOCKOUT_TICKS(8), .ACCEPT_TICKS(8),
		.LONG_TICKS(32)) uut (.clk_sys(clk_sys), .rst(rst), .straps(straps),
		.kick_input(kick), .vout_low(vout_low), .reset_out_n(reset_out_n), .mode_out(mode_out),
		.wd_timeout(wd_timeout), .early_kick(early_kick));
	// count fault pulses so each scenario can judge which fault ended it
	always @(posedge clk_sys) begin
		if (wd_timeout === 1'b1) to_cnt <= to_cnt + 1;
		if (early_kick === 1'b1) ek_cnt <= ek_cnt + 1;
	end
	host_model host (.clk_sys(clk_sys), .run(run), .half(half), .kick_input(kick));
	// 4 ns clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// verdict and end of run
	task automatic finish_test();
		if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// cycles the reset output stays at lvl, capped at 600
	task automatic span(input logic lvl, output int c);
		c = 0;
		while (reset_out_n === lvl && c < 600) begin
			@(negedge clk_sys);
			c++;
		end
	endtask
	// boot in a mode, then time hold, run and the following hold
	// f names the fault that ends the high span: 0 none, 1 timeout, 2 early kick
	task automatic meas(input logic a, b, k, input logic [7:0] hp, input wd_mode_t m, input int h, t, f);
		int c, t0, e0;
		@(posedge clk_sys);
		straps <= {a, b};
		run <= k;
		half <= hp;
		rst <= 1'b1;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		span(1'b0, c);
		`CHK(mode_out, m)
		`CHK(c > h - 16 && c < h + 16, 1'b1)
		t0 = to_cnt;
		e0 = ek_cnt;
		span(1'b1, c);
		`CHK(c > t - 16 && c < t + 16, 1'b1)
		`CHK(to_cnt - t0, int'(f == 1))
		`CHK(ek_cnt - e0, int'(f == 2))
		if (t < 600) begin
			span(1'b0, c);
		end else begin
			@(posedge clk_sys);
			vout_low <= 1'b1;
			@(posedge clk_sys);
			vout_low <= 1'b0;
			repeat (3) @(negedge clk_sys);
			`CHK(reset_out_n, 1'b0)
			span(1'b0, c);
		end
		`CHK(c > h - 16 && c < h + 16, 1'b1)
	endtask
	// watchdog against a hang
	initial begin
		#100000;
		fail_count++;
		finish_test();
	end
	initial begin
		rst = 1'b1;
		straps = '0;
		vout_low = 1'b0;
		run = 1'b0;
		half = 8'h18;
		meas(1'b0, 1'b0, 1'b0, 8'h18, MODE_FAST, 128, 144, 1); // no kicks: timeout
		meas(1'b0, 1'b0, 1'b1, 8'h18, MODE_FAST, 128, 600, 0); // good spacing
		meas(1'b0, 1'b0, 1'b1, 8'h08, MODE_FAST, 128, 48, 2); // kicks too early
		meas(1'b0, 1'b1, 1'b0, 8'h18, MODE_SLOW, 256, 288, 1); // slow timing
		meas(1'b1, 1'b0, 1'b0, 8'h18, MODE_FAST, 256, 144, 1); // fast, long hold
		meas(1'b1, 1'b1, 1'b1, 8'h18, MODE_OFF, 256, 600, 0); // off, kicks ignored
		finish_test();
	end
endmodule
`default_nettype wire
